/* design/fdcs_top.sv */
// Purpose: command, execution and result phases of the disk sequencer
// Assumes: the drive side gives a byte strobe per data byte and index
// Notes: DMA carries data; host sees only status and the data port
`timescale 1ns/1ns
`default_nettype none
module fdcs_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [7:0] hostWdata,
  output logic [7:0] hostRdata,
  output logic [7:0] mainStatus,
  output logic irqReq,
  input wire logic indexPulse,
  input wire logic diskByteStrobe,
  input wire logic [7:0] dmaRdata,
  output logic dmaReq,
  output logic dmaDirMemRead,
  input wire logic dmaAck,
  output logic [7:0] diskWdata,
  output logic diskWriteGate
);
  import fdcs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_CMD,
    ST_TURN,
    ST_EXEC,
    ST_FMTID,
    ST_RESULT
  } fdcs_state_e;

  fdcs_state_e state_r;
  fdcs_op_e op_r;
  fdcs_cmd_s cmd_r;
  logic [3:0] byteCnt_r;
  logic [3:0] turnCnt_r;
  logic [7:0] curSector_r;
  logic [10:0] secBytes_r;
  logic [2:0] resIdx_r;
  logic [2:0] fmtIdx_r;
  logic [1:0] indexSync_r;
  logic indexPrev_r;
  logic [1:0] indexSeen_r;
  logic [1:0] strobeSync_r;
  logic strobePrev_r;
  logic abnormal_r;
  logic [7:0] resByte;
  logic indexEdge;
  logic strobeEdge;
  logic [10:0] sectorLen;
  logic [3:0] cmdLen;

  ////////////////////////////////////////////////////////////////////
  // Pins from the drive cross in through two flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      indexSync_r <= 2'h0;
      strobeSync_r <= 2'h0;
      indexPrev_r <= 1'b0;
      strobePrev_r <= 1'b0;
    end else begin
      indexSync_r <= {indexSync_r[0], indexPulse};
      strobeSync_r <= {strobeSync_r[0], diskByteStrobe};
      indexPrev_r <= indexSync_r[1];
      strobePrev_r <= strobeSync_r[1];
    end
  end

  assign indexEdge = indexSync_r[1] & ~indexPrev_r;
  assign strobeEdge = strobeSync_r[1] & ~strobePrev_r;
  // Size code n gives 128 << n, using only the low two bits of n; byte nine only matters at code zero
  assign sectorLen = (cmd_r.sizeCode == 8'h00) ? {3'h0, cmd_r.dataLen}
                     : 11'(BYTES_128) << cmd_r.sizeCode[1:0];
  assign cmdLen = (op_r == FDCS_OP_FORMAT) ? LEN_FMT : LEN_RW;

  ////////////////////////////////////////////////////////////////////
  // Command phase: one byte per host write, counted by position
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_r <= FDCS_OP_NONE;
      cmd_r <= '0;
      byteCnt_r <= 4'h0;
    end else if (state_r == ST_CMD && hostWrite) begin
      byteCnt_r <= byteCnt_r + 4'h1;
      if (byteCnt_r == 4'h0) begin
        case (hostWdata)
          OP_READ: op_r <= FDCS_OP_READ;
          OP_WRITE: op_r <= FDCS_OP_WRITE;
          OP_FORMAT: op_r <= FDCS_OP_FORMAT;
          default: op_r <= FDCS_OP_NONE;
        endcase
      end else if (op_r == FDCS_OP_FORMAT) begin
        case (byteCnt_r)
          4'h1: cmd_r.driveHead <= hostWdata;
          4'h2: cmd_r.sizeCode <= hostWdata;
          4'h3: cmd_r.lastSectorNumber <= hostWdata;
          4'h4: cmd_r.gap <= hostWdata;
          4'h5: cmd_r.dataLen <= hostWdata;
          default: cmd_r.track <= cmd_r.track;
        endcase
      end else begin
        case (byteCnt_r)
          4'h1: cmd_r.driveHead <= hostWdata;
          4'h2: cmd_r.track <= hostWdata;
          4'h3: cmd_r.side <= hostWdata;
          4'h4: cmd_r.firstSector <= hostWdata;
          4'h5: cmd_r.sizeCode <= hostWdata;
          4'h6: cmd_r.lastSectorNumber <= hostWdata;
          4'h7: cmd_r.gap <= hostWdata;
          4'h8: cmd_r.dataLen <= hostWdata;
          default: cmd_r.track <= cmd_r.track;
        endcase
      end
    end else if (state_r == ST_TURN && turnCnt_r == 4'h0 &&
                 op_r == FDCS_OP_NONE) begin
      byteCnt_r <= 4'h0;
    end else if (state_r != ST_CMD && state_r != ST_TURN) begin
      // Count must survive the pacing gap between command bytes
      byteCnt_r <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer; the host must stay away while DMA runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_CMD;
      turnCnt_r <= 4'h0;
    end else begin
      case (state_r)
        ST_CMD: begin
          if (hostWrite) begin
            state_r <= ST_TURN;
            turnCnt_r <= TURN_CYCLES;
          end
        end
        ST_TURN: begin
          // Request drops briefly after each byte to pace the host
          if (turnCnt_r != 4'h0) begin
            turnCnt_r <= turnCnt_r - 4'h1;
          end else if (byteCnt_r == 4'h1 && op_r == FDCS_OP_NONE) begin
            state_r <= ST_CMD; // Unknown opcodes are dropped
          end else if (byteCnt_r == cmdLen) begin
            state_r <= (op_r == FDCS_OP_FORMAT) ? ST_FMTID : ST_EXEC;
          end else begin
            state_r <= ST_CMD;
          end
        end
        ST_FMTID: begin
          if (dmaAck && fmtIdx_r == FMT_ID_BYTES - 3'h1) begin
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (op_r == FDCS_OP_FORMAT) begin
            if (indexSeen_r == 2'h2) begin
              state_r <= ST_RESULT;
            end else if (strobeEdge && secBytes_r == 11'h001) begin
              state_r <= ST_FMTID;
            end
          end else if (strobeEdge && secBytes_r == 11'h001 &&
                       curSector_r == cmd_r.lastSectorNumber) begin
            state_r <= ST_RESULT;
          end
        end
        ST_RESULT: begin
          if (hostRead && resIdx_r == RESULT_COUNT - 3'h1) begin
            state_r <= ST_CMD;
          end
        end
        default: state_r <= ST_CMD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sector walk and data movement
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      curSector_r <= 8'h00;
      secBytes_r <= 11'h000;
      fmtIdx_r <= 3'h0;
      indexSeen_r <= 2'h0;
      abnormal_r <= 1'b0;
    end else if (state_r == ST_TURN) begin
      curSector_r <= cmd_r.firstSector;
      secBytes_r <= sectorLen;
      fmtIdx_r <= 3'h0;
      indexSeen_r <= 2'h0;
      abnormal_r <= 1'b0;
    end else begin
      if (indexEdge && op_r == FDCS_OP_FORMAT && indexSeen_r != 2'h2) begin
        indexSeen_r <= indexSeen_r + 2'h1;
      end
      if (state_r == ST_FMTID && dmaAck) begin
        fmtIdx_r <= fmtIdx_r + 3'h1;
        if (fmtIdx_r == 3'h2) begin
          curSector_r <= dmaRdata;
        end
        if (fmtIdx_r == FMT_ID_BYTES - 3'h1) begin
          fmtIdx_r <= 3'h0;
          secBytes_r <= sectorLen;
        end
      end
      if (state_r == ST_EXEC && strobeEdge) begin
        if (secBytes_r == 11'h001) begin
          secBytes_r <= sectorLen;
          curSector_r <= curSector_r + 8'h01;
          // No byte counter: ending at the last sector reads abnormal
          abnormal_r <= 1'b1;
        end else begin
          secBytes_r <= secBytes_r - 11'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Result phase
  fdcs_result_rom resultRom (
    .index(resIdx_r),
    .op(op_r),
    .cmd(cmd_r),
    .curSector(curSector_r),
    .abnormal(abnormal_r),
    .data(resByte)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resIdx_r <= 3'h0;
      hostRdata <= 8'h00;
    end else begin
      hostRdata <= resByte;
      if (state_r != ST_RESULT) begin
        resIdx_r <= 3'h0;
      end else if (hostRead) begin
        resIdx_r <= resIdx_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outward signals, all registered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mainStatus <= MSR_RESET;
      irqReq <= 1'b0;
      dmaReq <= 1'b0;
      dmaDirMemRead <= 1'b0;
      diskWdata <= 8'h00;
      diskWriteGate <= 1'b0;
    end else begin
      mainStatus <= 8'h00;
      mainStatus[MSR_REQ_BIT] <= (state_r == ST_CMD) ||
        (state_r == ST_RESULT && !(hostRead &&
         resIdx_r == RESULT_COUNT - 3'h1));
      mainStatus[MSR_DIR_BIT] <= (state_r == ST_RESULT) &&
        !(hostRead && resIdx_r == RESULT_COUNT - 3'h1);
      mainStatus[MSR_BUSY_BIT] <= (state_r != ST_CMD) ||
        (byteCnt_r != 4'h0);
      irqReq <= (state_r == ST_RESULT) && !(hostRead &&
        resIdx_r == RESULT_COUNT - 3'h1);
      dmaReq <= (state_r == ST_FMTID && !dmaAck) ||
        (state_r == ST_EXEC && op_r != FDCS_OP_FORMAT && strobeEdge);
      dmaDirMemRead <= (op_r != FDCS_OP_READ);
      diskWriteGate <= (state_r == ST_EXEC && op_r != FDCS_OP_READ);
      if (op_r == FDCS_OP_FORMAT) begin
        diskWdata <= cmd_r.dataLen;
      end else if (dmaAck) begin
        diskWdata <= dmaRdata;
      end
    end
  end

endmodule
`default_nettype wire

/* design/fdcs_pkg.sv */
// Purpose: constants and types for the floppy DMA command sequencer
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: command and result bytes pass through one data port
package fdcs_pkg;

  localparam logic [7:0] OP_READ = 8'h46;
  localparam logic [7:0] OP_WRITE = 8'h45;
  localparam logic [7:0] OP_FORMAT = 8'h4D;
  localparam logic [3:0] LEN_RW = 4'h9;
  localparam logic [3:0] LEN_FMT = 4'h6;
  localparam logic [2:0] RESULT_COUNT = 3'h7;
  localparam logic [2:0] FMT_ID_BYTES = 3'h4;
  localparam logic [7:0] ST0_RW_BASE = 8'h40;
  localparam logic [7:0] ST1_END_CYL = 8'h80;
  localparam logic [7:0] ST_ZERO = 8'h00;
  localparam logic [7:0] MSR_RESET = 8'h80;
  localparam int MSR_REQ_BIT = 7;
  localparam int MSR_DIR_BIT = 6;
  localparam int MSR_BUSY_BIT = 4;
  localparam logic [8:0] BYTES_128 = 9'h080;
  localparam int CMD_TURNAROUND_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [3:0] TURN_CYCLES =
    4'((CMD_TURNAROUND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    FDCS_OP_NONE,
    FDCS_OP_READ,
    FDCS_OP_WRITE,
    FDCS_OP_FORMAT
  } fdcs_op_e;

  typedef struct packed {
    logic [7:0] driveHead;
    logic [7:0] track;
    logic [7:0] side;
    logic [7:0] firstSector;
    logic [7:0] sizeCode;
    logic [7:0] lastSectorNumber;
    logic [7:0] gap;
    logic [7:0] dataLen;
  } fdcs_cmd_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fdcs_byte_s;

endpackage

/* design/fdcs_result_rom.sv */
// Purpose: selects one of the seven result bytes by index
// Assumes: caller registers the output
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
module fdcs_result_rom (
  input wire logic [2:0] index,
  input wire fdcs_pkg::fdcs_op_e op,
  input wire fdcs_pkg::fdcs_cmd_s cmd,
  input wire logic [7:0] curSector,
  input wire logic abnormal,
  output logic [7:0] data
);
  import fdcs_pkg::*;

  always_comb begin
    case (index)
      3'h0: begin
        if (op == FDCS_OP_FORMAT) begin
          data = {5'h00, cmd.driveHead[2:0]};
        end else begin
          data = ST0_RW_BASE | {5'h00, cmd.driveHead[2:0]};
        end
      end
      3'h1: data = (op == FDCS_OP_FORMAT || !abnormal) ? ST_ZERO
                   : ST1_END_CYL;
      3'h2: data = ST_ZERO;
      3'h3: data = cmd.track;
      3'h4: data = cmd.side;
      3'h5: data = curSector;
      3'h6: data = cmd.sizeCode;
      default: data = ST_ZERO;
    endcase
  end

endmodule
`default_nettype wire

/* dv/fdcs_properties.sv */
// Purpose: port checks for fdcs_top
// Assumes: one clock, sync active-high reset
// Notes: bound into fdcs_top below the module
`timescale 1ns/1ns
`default_nettype none
module fdcs_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [7:0] mainStatus,
  input wire logic irqReq,
  input wire logic dmaReq,
  input wire logic diskWriteGate
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  reset_status_a: assert property (disable iff (1'b0)
    sys_rst |=> mainStatus == 8'h80) else $error("status not idle");
  write_take_a: assert property (
    hostWrite && mainStatus[7] && !mainStatus[6] |-> ##2 !mainStatus[7])
    else $error("request flag kept after write");
  irq_dir_a: assert property (irqReq |-> mainStatus[6])
    else $error("interrupt without result direction");
  irq_ready_a: assert property (
    $rose(irqReq) |-> mainStatus[7] && mainStatus[6])
    else $error("interrupt before results ready");
  spare_zero_a: assert property (
    mainStatus[5] == 1'b0 && mainStatus[3:0] == 4'h0)
    else $error("spare status bits set");
  dma_busy_a: assert property (
    dmaReq |-> mainStatus[4] && !mainStatus[7])
    else $error("dma outside busy phase");
  gate_irq_a: assert property (diskWriteGate |-> !irqReq)
    else $error("interrupt while writing");
  irq_fall_a: assert property (
    $fell(irqReq) |-> $past(hostRead) || $past(hostRead, 2))
    else $error("interrupt dropped without read");
  cover property (hostWrite && mainStatus[7]);
  cover property ($rose(irqReq));
  cover property ($fell(diskWriteGate));
endmodule
bind fdcs_top fdcs_properties fdcs_properties_inst (.clk(clk),
  .sys_rst(sys_rst), .hostWrite(hostWrite), .hostRead(hostRead),
  .mainStatus(mainStatus), .irqReq(irqReq), .dmaReq(dmaReq),
  .diskWriteGate(diskWriteGate));
`default_nettype wire

/* dv/fdcs_drive_model.sv */
// Purpose: drive and DMA memory side of the sequencer
// Assumes: disk spins always, so strobes and index run free
// Notes: ids go out descending to show any order is taken
`timescale 1ns/1ns
`default_nettype none
module fdcs_drive_model #(
  parameter int INDEX_PERIOD = 4000,
  parameter logic [3:0] ACK_DELAY = 4'h3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dmaReq,
  input wire logic [7:0] idTrack,
  input wire logic [7:0] idSize,
  output logic indexPulse,
  output logic diskByteStrobe,
  output logic dmaAck,
  output logic [7:0] dmaRdata
);
  logic [15:0] tick_r;
  logic reqSeen_r;
  logic [3:0] ackWait_r;
  logic [7:0] idCnt_r;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_r <= 16'h0000;
      indexPulse <= 1'b0;
      diskByteStrobe <= 1'b0;
    end else begin
      tick_r <= (tick_r >= 16'(INDEX_PERIOD - 1)) ? 16'h0000
                : tick_r + 16'h0001;
      indexPulse <= tick_r < 16'h0008;
      diskByteStrobe <= tick_r[2];
    end
  end
  // Slow ack on purpose: memory is not zero-wait
  always_ff @(posedge clk) begin
    reqSeen_r <= dmaReq;
    dmaAck <= ackWait_r == 4'h1;
    if (sys_rst) ackWait_r <= 4'h0;
    else if (dmaReq && !reqSeen_r) ackWait_r <= ACK_DELAY;
    else if (ackWait_r != 4'h0) ackWait_r <= ackWait_r - 4'h1;
  end
  // Four id bytes per sector, size equal to command size
  always_ff @(posedge clk) begin
    if (sys_rst) idCnt_r <= 8'h00;
    else if (ackWait_r == 4'h1) idCnt_r <= idCnt_r + 8'h01;
    if (ackWait_r == 4'h1) begin
      case (idCnt_r[1:0])
        2'h0: dmaRdata <= idTrack;
        2'h1: dmaRdata <= 8'h00;
        2'h2: dmaRdata <= 8'h1A - {2'h0, idCnt_r[7:2]};
        default: dmaRdata <= idSize;
      endcase
    end else dmaRdata <= ~dmaRdata;
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: self-checking bench for fdcs_top
// Assumes: host polls status before every byte
// Notes: random drive, track and sector, fixed seed
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fdcs_pkg::*;
  logic clk, sys_rst, hostWrite, hostRead, lastReq, dirSeen, gateSeen;
  logic irqReq, indexPulse, diskByteStrobe, dmaReq, dmaDirMemRead;
  logic dmaAck, diskWriteGate;
  logic [7:0] hostWdata, hostRdata, mainStatus, dmaRdata, diskWdata;
  logic [7:0] fillSeen, dh, trk, sec, last, op;
  integer seed = 32'hfcd9;
  int n_mismatch = 0;
  int comparisons = 0;
  int reqCount = 0;
  fdcs_top fdcs_top_inst (.clk(clk), .sys_rst(sys_rst),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostWdata(hostWdata),
    .hostRdata(hostRdata), .mainStatus(mainStatus), .irqReq(irqReq),
    .indexPulse(indexPulse), .diskByteStrobe(diskByteStrobe),
    .dmaRdata(dmaRdata), .dmaReq(dmaReq), .dmaDirMemRead(dmaDirMemRead),
    .dmaAck(dmaAck), .diskWdata(diskWdata), .diskWriteGate(diskWriteGate));
  fdcs_drive_model fdcs_drive_model_inst (.clk(clk), .sys_rst(sys_rst),
    .dmaReq(dmaReq), .idTrack(trk), .idSize(8'h01),
    .indexPulse(indexPulse), .diskByteStrobe(diskByteStrobe),
    .dmaAck(dmaAck), .dmaRdata(dmaRdata));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    lastReq <= dmaReq;
    if (dmaReq && !lastReq) begin
      reqCount++;
      dirSeen = dmaDirMemRead;
    end
    if (diskWriteGate) begin
      gateSeen = 1'b1;
      fillSeen = diskWdata;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic send_cmd(input logic [71:0] b, input int n);
    int i;
    for (int k = 0; k < n; k++) begin
      i = 0;
      while (!(mainStatus[7] && !mainStatus[6]) && i < 100) begin
        @(posedge clk);
        i++;
      end
      if (i == 100) n_mismatch++;
      hostWdata <= b[71-8*k -: 8];
      hostWrite <= 1'b1;
      @(posedge clk);
      hostWrite <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic get_results(input logic [55:0] e, input logic [6:0] m);
    int i;
    for (int k = 0; k < 7; k++) begin
      i = 0;
      while (!(mainStatus[7] && mainStatus[6]) && i < 30000) begin
        @(posedge clk);
        i++;
      end
      if (i == 30000) n_mismatch++;
      if (k == 0) check(16'(irqReq), 16'h0001);
      if (m[k]) check(16'(hostRdata), 16'(e[55-8*k -: 8]));
      hostRead <= 1'b1;
      @(posedge clk);
      hostRead <= 1'b0;
      repeat (3) @(posedge clk);
    end
    check(16'(mainStatus[6]), 16'h0000);
  endtask
  // Every transfer, one sector or three, ends abnormal but still reports the end flag
  function automatic logic [55:0] rw_expect(input logic [7:0] d, t);
    return {8'h40 | {5'h00, d[2:0]}, 8'h80, 8'h00, t, 7'h00, d[2], 16'h01};
  endfunction
  initial begin
    sys_rst = 1'b1;
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostWdata = 8'h00;
    trk = 8'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(16'(mainStatus), 16'h0080);
    send_cmd({8'h00, 64'h0}, 1);
    repeat (8) @(posedge clk);
    check(16'(mainStatus), 16'h0080);
    $display("test reset and refusal done");
    for (int t = 0; t < 4; t++) begin
      dh = 8'($random(seed)) & 8'h07;
      trk = 8'($random(seed)) & 8'h3F;
      sec = 8'h01 + (8'($random(seed)) & 8'h0F);
      last = sec + ((t % 2 == 1) ? 8'h02 : 8'h00);
      op = (t < 2) ? OP_READ : OP_WRITE;
      reqCount = 0;
      gateSeen = 1'b0;
      send_cmd({op, dh, trk, 7'h00, dh[2], sec, 8'h01, last, 8'h0E, 8'hFF},
        9);
      get_results(rw_expect(dh, trk), 7'b1011111);
      check(16'(reqCount), 16'({8'h00, last - sec + 8'h01}) * 16'd256);
      check(16'(dirSeen), 16'(op == OP_WRITE));
      check(16'(gateSeen), 16'(op == OP_WRITE));
      // No seek is ever issued, so erase settling cannot be cut short
      $display("test transfer %0d done", t);
    end
    dh = 8'($random(seed)) & 8'h07;
    reqCount = 0;
    send_cmd({OP_FORMAT, dh, 8'h01, 8'h1A, 8'h36, 8'hEA, 24'h0}, 6);
    get_results({5'h00, dh[2:0], 48'h0}, 7'b0000111);
    check(16'(reqCount % 4), 16'h0000);
    check(16'(reqCount > 0), 16'h0001);
    check(16'(dirSeen), 16'h0001);
    check(16'(fillSeen), 16'h00EA);
    $display("test format done");
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
